// File: shared/pmw_map.svh
// register offsets, field positions, reset values and limits of the mode and wait-state block
`ifndef PMW_MAP_SVH
`define PMW_MAP_SVH

// byte offsets on the register bus
`define PMW_OFF_MODE 8'h00
`define PMW_OFF_WS_CFG 8'h28
`define PMW_OFF_WS_CTRL 8'h2C
`define PMW_OFF_STATUS 8'h30

// processor_mode_status fields
`define PMW_MODE_VECTOR_PAGE_POINTER_LSB 7
`define PMW_MODE_VECTOR_PAGE_POINTER_MSB 15
`define PMW_MODE_ROM_BIT 6
`define PMW_MODE_RAM_OVERLAY_BIT 5
`define PMW_MODE_TRACE_BIT 4
`define PMW_MODE_RSVD_BIT 3
`define PMW_MODE_CLOCK_OUTPUT_DISABLE_BIT 2
`define PMW_MODE_MULTIPLY_SATURATE_BIT 1
`define PMW_MODE_SST_BIT 0
`define PMW_VECTOR_PAGE_POINTER_RESET 9'h1FF

// wait_state_config fields, three bits each
`define PMW_WS_XPA_BIT 15
`define PMW_WS_IO_LSB 12
`define PMW_WS_UDATA_LSB 9
`define PMW_WS_LDATA_LSB 6
`define PMW_WS_UPROG_LSB 3
`define PMW_WS_PROG_LSB 0
`define PMW_WS_FIELDS_MSB 13
`define PMW_WS_CFG_RESET 16'h7FFF
`define PMW_WS_DBL_BIT 0
`define PMW_WS_MAX 4'hE

// on-chip memory limits
`define PMW_RAM_LO 16'h0080
`define PMW_RAM_HI 16'h3FFF
`define PMW_ROM_LO 16'hC000

`endif

// File: shared/pmw_pkg.sv
// types shared by the mode and wait-state block
package pmw_pkg;

   typedef enum logic [1:0] {
      PMW_SPACE_PROG = 2'b00,
      PMW_SPACE_DATA = 2'b01,
      PMW_SPACE_IO = 2'b10
   } pmw_space_e;

   typedef enum logic [1:0] {
      PMW_ST_IDLE = 2'b00,
      PMW_ST_WAIT = 2'b01,
      PMW_ST_DONE = 2'b10
   } pmw_state_e;

   typedef struct packed {
      logic req;
      pmw_space_e space;
      logic [15:0] addr;
   } pmw_access_s;

endpackage

// File: hw/pmw_ahb_slave.sv
// ahb-lite slave front end: one wait state on reads, none on writes
`timescale 1ns/1ps
`default_nettype none

module pmw_ahb_slave
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // ahb-lite side
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [15:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // register side
   output logic [7:0] reg_addr,
   output logic wr_en,
   output logic [15:0] wdata,
   input wire logic [15:0] rdata
);

   logic [7:0] addr_q;
   logic wr_pend_q;
   logic rd_pend_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic hresp_q;
   wire take = hsel & htrans[1] & hready;

   ////////////////////////////////////////////////////////////////////////
   // read data is registered, so reads cost one wait state
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         addr_q <= 8'h00;
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         hrdata_q <= 32'h00000000;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end
      else if (rd_pend_q)
      begin
         hrdata_q <= {16'h0000, rdata};
         hreadyout_q <= 1'b1;
         rd_pend_q <= 1'b0;
         wr_pend_q <= 1'b0;
      end
      else
      begin
         wr_pend_q <= take & hwrite & (hsize == 3'h2);
         rd_pend_q <= take & ~hwrite;
         hreadyout_q <= ~(take & ~hwrite);
         if (take)
         begin
            addr_q <= haddr;
         end
      end
   end

   assign reg_addr = addr_q;
   assign wr_en = wr_pend_q;
   assign wdata = hwdata;
   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;

endmodule
`default_nettype wire

// File: hw/pmw_wait_ctr.sv
// down-counter that stretches one external access
`timescale 1ns/1ps
`default_nettype none

module pmw_wait_ctr
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // control
   input wire logic run,
   input wire logic load,
   input wire logic [3:0] load_val,
   input wire logic ext_ready,
   // state
   output logic [3:0] count,
   output logic expire
);

   logic [3:0] count_q;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_q <= 4'h0;
      end
      else if (load)
      begin
         count_q <= load_val;
      end
      else if (run && count_q != 4'h0)
      begin
         count_q <= count_q - 4'h1;
      end
   end

   assign count = count_q;
   // ready held low keeps stretching past the programmed count
   assign expire = (count_q == 4'h0) & ext_ready;

endmodule
`default_nettype wire

// File: hw/pmw_regs.sv
// processor mode register, wait-state generator and external access timing
// Function
// - nine-bit vector page pointer in bits 15..7
// - hard reset sets pointer ones; soft keeps
// - bit 6 clear maps on-chip ROM in program
// - ROM select loaded from pin at reset
// - soft reset leaves ROM select alone
// - bit 5 overlays RAM into program space
// - data page zero never in program
// - trace off: address bus holds last
// - trace on: program address on pins
// - bit 2 stops clock output, high
// - bit 1 saturates product when overflow+fractional
// - bit 0 saturates stores after shift
// - software waits stretch up to fourteen
// - ready low extends access indefinitely
// - all-zero waits gate generator clock off; code tests only bits 13..0, so an IO count of 4 alone also gates it
// - low 15 bits: five three-bit counts
// - doubler bit scales counts by two
// - hard reset gives seven waits everywhere
// - wait config at offset 28h
// - internal data served inside, else external
// - RAM decoded at 0080h through 3FFFh
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "pmw_map.svh"

module pmw_regs
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // ahb-lite register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // core side
   input wire pmw_pkg::pmw_access_s acc,
   input wire logic [15:0] pc_addr,
   input wire logic soft_reset,
   input wire logic overflow_mode,
   input wire logic fractional_mode,
   input wire logic rom_map_pin,
   output logic acc_done_q,
   // external parallel bus
   input wire logic ext_ready,
   output logic [15:0] ext_addr_q,
   output logic ext_strobe_q,
   output var pmw_pkg::pmw_space_e ext_space_q,
   // mode outputs
   output logic [15:0] vector_base_q,
   output logic rom_sel_q,
   output logic ram_sel_q,
   output logic mult_sat_q,
   output logic store_sat_q,
   output logic clock_output_pin_q,
   output logic wsg_clk_en_q
);

   ////////////////////////////////////////////////////////////////////////
   // declarations

   logic [8:0] vector_page_pointer_q;
   logic rom_map_select_q;
   logic ram_overlay_q;
   logic address_trace_enable_q;
   logic clock_output_disable_q;
   logic multiply_saturate_q;
   logic store_saturate_q;
   logic strap_done_q;
   logic [15:0] ws_cfg_q;
   logic wait_state_doubler_q;
   pmw_pkg::pmw_state_e state_q;
   pmw_pkg::pmw_state_e state_d;
   logic [7:0] reg_addr;
   logic bus_wr;
   logic [15:0] bus_wdata;
   logic [15:0] rdata;
   logic [3:0] wait_count;
   logic wait_expire;

   ////////////////////////////////////////////////////////////////////////
   // functions

   function automatic logic in_ram(input logic [15:0] a);
      in_ram = (a >= `PMW_RAM_LO) && (a <= `PMW_RAM_HI);
   endfunction

   // base count of the range an address falls in
   function automatic logic [2:0] pick_base(input logic [15:0] cfg,
                                            input pmw_pkg::pmw_space_e sp,
                                            input logic hi);
      logic [2:0] b;
      b = cfg[`PMW_WS_PROG_LSB +: 3];
      unique case (sp)
         pmw_pkg::PMW_SPACE_PROG:
         begin
            b = hi ? cfg[`PMW_WS_UPROG_LSB +: 3] : cfg[`PMW_WS_PROG_LSB +: 3];
         end
         pmw_pkg::PMW_SPACE_DATA:
         begin
            b = hi ? cfg[`PMW_WS_UDATA_LSB +: 3] : cfg[`PMW_WS_LDATA_LSB +: 3];
         end
         pmw_pkg::PMW_SPACE_IO:
         begin
            b = cfg[`PMW_WS_IO_LSB +: 3];
         end
         default:
         begin
            b = cfg[`PMW_WS_IO_LSB +: 3];
         end
      endcase
      pick_base = b;
   endfunction

   // doubled count never exceeds fourteen
   function automatic logic [3:0] scale_waits(input logic [2:0] base, input logic dbl);
      scale_waits = dbl ? {base, 1'b0} : {1'b0, base};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // bus front end

   pmw_ahb_slave u_slave
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .hsel(hsel),
      .haddr(haddr[7:0]),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hready(hready),
      .hwdata(hwdata[15:0]),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .reg_addr(reg_addr),
      .wr_en(bus_wr),
      .wdata(bus_wdata),
      .rdata(rdata)
   );

   wire sel_mode = reg_addr == `PMW_OFF_MODE;
   wire sel_ws_cfg = reg_addr == `PMW_OFF_WS_CFG;
   wire sel_ws_ctrl = reg_addr == `PMW_OFF_WS_CTRL;
   wire sel_status = reg_addr == `PMW_OFF_STATUS;
   wire wr_mode = bus_wr & sel_mode;
   wire wr_ws_cfg = bus_wr & sel_ws_cfg;
   wire wr_ws_ctrl = bus_wr & sel_ws_ctrl;

   wire [15:0] rd_mode = {vector_page_pointer_q, rom_map_select_q, ram_overlay_q,
                          address_trace_enable_q, 1'b0, clock_output_disable_q,
                          multiply_saturate_q, store_saturate_q};
   wire [15:0] rd_ws_ctrl = {15'h0000, wait_state_doubler_q};
   wire [15:0] rd_status = {8'h00, wait_count, state_q, wsg_clk_en_q, strap_done_q};
   assign rdata = sel_mode ? rd_mode :
                  sel_ws_cfg ? ws_cfg_q :
                  sel_ws_ctrl ? rd_ws_ctrl :
                  sel_status ? rd_status : 16'h0000;

   ////////////////////////////////////////////////////////////////////////
   // mode register

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vector_page_pointer_q <= `PMW_VECTOR_PAGE_POINTER_RESET;
         ram_overlay_q <= 1'b0;
         address_trace_enable_q <= 1'b0;
         clock_output_disable_q <= 1'b0;
         multiply_saturate_q <= 1'b0;
         store_saturate_q <= 1'b0;
      end
      else if (wr_mode)
      begin
         vector_page_pointer_q <= bus_wdata[`PMW_MODE_VECTOR_PAGE_POINTER_MSB:`PMW_MODE_VECTOR_PAGE_POINTER_LSB];
         ram_overlay_q <= bus_wdata[`PMW_MODE_RAM_OVERLAY_BIT];
         address_trace_enable_q <= bus_wdata[`PMW_MODE_TRACE_BIT];
         clock_output_disable_q <= bus_wdata[`PMW_MODE_CLOCK_OUTPUT_DISABLE_BIT];
         multiply_saturate_q <= bus_wdata[`PMW_MODE_MULTIPLY_SATURATE_BIT];
         store_saturate_q <= bus_wdata[`PMW_MODE_SST_BIT];
      end
      else if (soft_reset)
      begin
         // pointer left as is on the reset instruction
         ram_overlay_q <= 1'b0;
         address_trace_enable_q <= 1'b0;
         clock_output_disable_q <= 1'b0;
         multiply_saturate_q <= 1'b0;
         store_saturate_q <= 1'b0;
      end
   end

   // the pin is caught on the first edge after release, never again
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rom_map_select_q <= 1'b0;
         strap_done_q <= 1'b0;
      end
      else if (!strap_done_q)
      begin
         rom_map_select_q <= rom_map_pin;
         strap_done_q <= 1'b1;
      end
      else if (wr_mode)
      begin
         rom_map_select_q <= bus_wdata[`PMW_MODE_ROM_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // wait-state registers

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ws_cfg_q <= `PMW_WS_CFG_RESET;
         wait_state_doubler_q <= 1'b0;
      end
      else
      begin
         if (wr_ws_cfg)
         begin
            ws_cfg_q <= bus_wdata;
         end
         if (wr_ws_ctrl)
         begin
            wait_state_doubler_q <= bus_wdata[`PMW_WS_DBL_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // address decode of the pending access

   wire rom_hit = ~rom_map_select_q & (acc.addr >= `PMW_ROM_LO);
   // page zero sits below the ram window, so the overlay never reaches it
   wire ram_overlay_hit = ram_overlay_q & in_ram(acc.addr);
   wire prog_int = rom_hit | ram_overlay_hit;
   wire data_int = acc.addr <= `PMW_RAM_HI;
   wire data_ram = in_ram(acc.addr);
   wire is_prog = acc.space == pmw_pkg::PMW_SPACE_PROG;
   wire is_data = acc.space == pmw_pkg::PMW_SPACE_DATA;
   wire acc_int = (is_prog & prog_int) | (is_data & data_int);
   wire start = (state_q == pmw_pkg::PMW_ST_IDLE) & acc.req;
   wire start_ext = start & ~acc_int;
   wire [2:0] base_waits = pick_base(ws_cfg_q, acc.space, acc.addr[15]);
   wire [3:0] load_waits = scale_waits(base_waits, wait_state_doubler_q);
   wire in_wait = state_q == pmw_pkg::PMW_ST_WAIT;
   wire wsg_any = |ws_cfg_q[`PMW_WS_FIELDS_MSB:0];

   ////////////////////////////////////////////////////////////////////////
   // wait counter and access sequencer

   pmw_wait_ctr u_wait
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .run(in_wait & wsg_clk_en_q),
      .load(start_ext),
      .load_val(load_waits),
      .ext_ready(ext_ready),
      .count(wait_count),
      .expire(wait_expire)
   );

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         pmw_pkg::PMW_ST_IDLE:
         begin
            if (start_ext)
            begin
               state_d = pmw_pkg::PMW_ST_WAIT;
            end
            else if (start)
            begin
               state_d = pmw_pkg::PMW_ST_DONE;
            end
         end
         pmw_pkg::PMW_ST_WAIT:
         begin
            if (wait_expire)
            begin
               state_d = pmw_pkg::PMW_ST_DONE;
            end
         end
         pmw_pkg::PMW_ST_DONE:
         begin
            state_d = pmw_pkg::PMW_ST_IDLE;
         end
         default:
         begin
            state_d = pmw_pkg::PMW_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= pmw_pkg::PMW_ST_IDLE;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // external bus outputs

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_addr_q <= 16'h0000;
         ext_strobe_q <= 1'b0;
         ext_space_q <= pmw_pkg::PMW_SPACE_PROG;
         acc_done_q <= 1'b0;
      end
      else
      begin
         acc_done_q <= state_d == pmw_pkg::PMW_ST_DONE && state_q != pmw_pkg::PMW_ST_DONE;
         ext_strobe_q <= state_d == pmw_pkg::PMW_ST_WAIT;
         if (start_ext)
         begin
            ext_addr_q <= acc.addr;
            ext_space_q <= acc.space;
         end
         else if (address_trace_enable_q && !in_wait)
         begin
            ext_addr_q <= pc_addr;
         end
         // otherwise the pins keep the last external address
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mode-driven outputs

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vector_base_q <= 16'hFF80;
         rom_sel_q <= 1'b0;
         ram_sel_q <= 1'b0;
         mult_sat_q <= 1'b0;
         store_sat_q <= 1'b0;
         clock_output_pin_q <= 1'b1;
         wsg_clk_en_q <= 1'b1;
      end
      else
      begin
         vector_base_q <= {vector_page_pointer_q, 7'h00};
         rom_sel_q <= start & is_prog & rom_hit;
         ram_sel_q <= start & ((is_prog & ram_overlay_hit) | (is_data & data_ram));
         mult_sat_q <= multiply_saturate_q & overflow_mode & fractional_mode;
         store_sat_q <= store_saturate_q;
         // held high when disabled so the far side sees no stray edge
         clock_output_pin_q <= clock_output_disable_q | ~clock_output_pin_q;
         wsg_clk_en_q <= wsg_any;
      end
   end

endmodule
`default_nettype wire

// File: testbench/pmw_regs_assertions.sv
// concurrent checks on the ports of the mode and wait-state block
`timescale 1ns/1ps
`default_nettype none

module pmw_regs_checker
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic hreadyout,
   // core and external bus
   input wire logic overflow_mode,
   input wire logic fractional_mode,
   input wire logic acc_done_q,
   input wire logic ext_ready,
   input wire logic [15:0] ext_addr_q,
   input wire logic ext_strobe_q,
   // mode outputs
   input wire logic [15:0] vector_base_q,
   input wire logic mult_sat_q,
   input wire logic clock_output_pin_q,
   input wire logic wsg_clk_en_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////////////
   // ready-high cycles inside one access; the down-counter alone must end it
   logic [4:0] rdy_cnt_q;
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         rdy_cnt_q <= 5'h00;
      else
         rdy_cnt_q <= ext_strobe_q ? rdy_cnt_q + {4'h0, ext_ready} : 5'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   sequence read_take;
      hsel && htrans[1] && hready && !hwrite;
   endsequence
   sequence ws_write;
      hsel && htrans[1] && hready && hwrite && hsize == 3'h2 && haddr[7:0] == 8'h28;
   endsequence

   read_wait_a: assert property (read_take |=> !hreadyout ##1 hreadyout)
      else $error("read data phase length wrong");
   vec_page_a: assert property (vector_base_q[6:0] == 7'h00)
      else $error("vector base not page aligned");
   clk_low_a: assert property (!clock_output_pin_q |=> clock_output_pin_q)
      else $error("clock pin low two cycles");
   addr_hold_a: assert property (ext_strobe_q && $past(ext_strobe_q) |-> $stable(ext_addr_q))
      else $error("address moved during access");
   strobe_done_a: assert property ($fell(ext_strobe_q) |-> acc_done_q)
      else $error("strobe ended without done");
   done_pulse_a: assert property (acc_done_q |=> !acc_done_q)
      else $error("done longer than one cycle");
   ready_ext_a: assert property (ext_strobe_q && !ext_ready |=> ext_strobe_q)
      else $error("access ended while not ready");
   wait_max_a: assert property (rdy_cnt_q <= 5'h0F)
      else $error("more than fourteen waits");
   sat_cause_a: assert property (mult_sat_q |-> $past(overflow_mode) && $past(fractional_mode))
      else $error("product saturate without both modes");
   gate_off_a: assert property (ws_write ##1 hwdata[13:0] == 14'h0000 |-> ##[1:2] !wsg_clk_en_q)
      else $error("generator clock not gated");
endmodule

bind pmw_regs pmw_regs_checker chk
(
   .ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hreadyout,
   .overflow_mode, .fractional_mode, .acc_done_q, .ext_ready, .ext_addr_q, .ext_strobe_q,
   .vector_base_q, .mult_sat_q, .clock_output_pin_q, .wsg_clk_en_q
);

`default_nettype wire

// File: testbench/pmw_ext_model.sv
// external memory model: ready withheld for a commanded stall
`timescale 1ns/1ps
`default_nettype none

module pmw_ext_model
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // parallel bus
   input wire logic ext_strobe_q,
   input wire logic [7:0] stall,
   output logic ext_ready
);
   logic [7:0] cnt_q;
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= 8'h00;
      else
         cnt_q <= ext_strobe_q ? cnt_q + 8'h01 : 8'h00;
   end
   // ready is low outside accesses, so a design that ignores it cannot pass
   assign ext_ready = ext_strobe_q && (cnt_q >= stall);
endmodule

`default_nettype wire

// File: testbench/proc_mode_and_wait_states_tb_top.sv
// self-checking bench for the mode and wait-state register bank
`timescale 1ns/1ps
`default_nettype none
`include "pmw_map.svh"

module proc_mode_and_wait_states_tb_top;
   logic ref_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, soft_reset = 1'b0;
   logic overflow_mode = 1'b0, fractional_mode = 1'b0, rom_map_pin = 1'b1;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [15:0] pc_addr = 16'h0, ext_addr_q, vector_base_q;
   logic [7:0] stall = 8'h00;
   pmw_pkg::pmw_access_s acc = '0;
   pmw_pkg::pmw_space_e ext_space_q;
   logic hreadyout, hresp, acc_done_q, ext_ready, ext_strobe_q, rom_sel_q, ram_sel_q;
   logic mult_sat_q, store_sat_q, clock_output_pin_q, wsg_clk_en_q;
   int fail_count = 0;
   int num_checks = 0;

   pmw_regs uut (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .acc, .pc_addr, .soft_reset,
      .overflow_mode, .fractional_mode, .rom_map_pin, .acc_done_q, .ext_ready, .ext_addr_q,
      .ext_strobe_q, .ext_space_q, .vector_base_q, .rom_sel_q, .ram_sel_q, .mult_sat_q,
      .store_sat_q, .clock_output_pin_q, .wsg_clk_en_q);
   pmw_ext_model mem (.ref_clk, .rst_n, .ext_strobe_q, .stall, .ext_ready);

   initial forever #20 ref_clk = ~ref_clk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // single word transfer; no wait count assumed, the watchdog bounds it
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] q);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {16'h0, d};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string n);
      logic [31:0] q;
      bus(1'b0, a, 16'h0, q);
      check(n, q, {16'h0, e});
      check("resp", hresp, 1'b0);
   endtask

   // cyc counts cycles with the strobe up, hit flags an on-chip answer
   task automatic access(input pmw_pkg::pmw_space_e sp, input logic [15:0] a,
                         output int cyc, output logic hit);
      cyc = 0;
      hit = 1'b0;
      @(posedge ref_clk);
      acc <= '{1'b1, sp, a};
      for (int i = 0; i < 100 && acc_done_q !== 1'b1; i++)
      begin
         @(posedge ref_clk);
         cyc += (ext_strobe_q === 1'b1);
         hit = hit | (rom_sel_q === 1'b1) | (ram_sel_q === 1'b1);
      end
      acc.req <= 1'b0;
      check("done", acc_done_q, 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      int c;
      logic h;
      @(posedge ref_clk);
      rom_map_pin <= 1'b0;
      check("vector base", vector_base_q, 16'hFF80);
      check("gen clk en", wsg_clk_en_q, 1'b1);
      rdc(`PMW_OFF_MODE, 16'hFFC0, "mode reset");
      rdc(`PMW_OFF_WS_CFG, 16'h7FFF, "ws reset");
      wr(8'h3C, 16'hFFFF);
      rdc(8'h3C, 16'h0000, "unmapped");
      access(pmw_pkg::PMW_SPACE_IO, 16'h1234, c, h);
      check("reset waits", c, 8);
   endtask

   task automatic t_mode();
      wr(`PMW_OFF_MODE, 16'hFFFF);
      rdc(`PMW_OFF_MODE, 16'hFFF7, "mode all");
      wr(`PMW_OFF_MODE, 16'h52F3);
      // pointer lands at the end of the data phase, the output one edge later
      repeat (2) @(posedge ref_clk);
      check("vector base", vector_base_q, 16'h5280);
      @(posedge ref_clk);
      soft_reset <= 1'b1;
      @(posedge ref_clk);
      soft_reset <= 1'b0;
      rdc(`PMW_OFF_MODE, 16'h52C0, "soft reset");
   endtask

   task automatic t_clock();
      logic p;
      wr(`PMW_OFF_MODE, 16'h0000);
      p = clock_output_pin_q;
      @(posedge ref_clk);
      check("clk toggles", clock_output_pin_q, {31'h0, ~p});
      wr(`PMW_OFF_MODE, 16'h0004);
      @(posedge ref_clk);
      repeat (8)
      begin
         @(posedge ref_clk);
         check("clk held", clock_output_pin_q, 1'b1);
      end
   endtask

   task automatic t_sat();
      for (int i = 0; i < 8; i++)
      begin
         overflow_mode <= i[0];
         fractional_mode <= i[1];
         wr(`PMW_OFF_MODE, {14'h0, i[2], i[2]});
         repeat (2) @(posedge ref_clk);
         check("mult sat", mult_sat_q, i[2] & i[1] & i[0]);
         check("store sat", store_sat_q, i[2]);
      end
   endtask

   // entries: mode, external flag and space, address
   task automatic t_map();
      logic [35:0] tb [9] = '{36'h0000_0_C000, 36'h0000_4_0100, 36'h0000_1_0080,
         36'h0000_1_3FFF, 36'h0000_5_4000, 36'h0000_6_0010, 36'h0060_4_C000,
         36'h0060_0_0100, 36'h0060_4_0040};
      int c;
      logic h;
      foreach (tb[i])
      begin
         wr(`PMW_OFF_MODE, tb[i][35:20]);
         access(pmw_pkg::pmw_space_e'(tb[i][17:16]), tb[i][15:0], c, h);
         check("external", c > 0, tb[i][18]);
         check("on chip", h, !tb[i][18]);
      end
   endtask

   // entries: base count, space, address of each of the five ranges
   task automatic t_waits();
      logic [23:0] wt [5] = '{24'h5_2_0010, 24'h3_1_8000, 24'h6_1_4000, 24'h1_0_8000,
         24'h2_0_0100};
      int c;
      logic h;
      wr(`PMW_OFF_MODE, 16'h0000);
      wr(`PMW_OFF_WS_CFG, 16'h578A);
      rdc(`PMW_OFF_WS_CFG, 16'h578A, "ws cfg");
      for (int d = 0; d < 2; d++)
      begin
         wr(`PMW_OFF_WS_CTRL, {15'h0, d[0]});
         foreach (wt[i])
         begin
            access(pmw_pkg::pmw_space_e'(wt[i][17:16]), wt[i][15:0], c, h);
            check("waits", c, wt[i][23:20] * (d + 1) + 1);
         end
      end
      wr(`PMW_OFF_WS_CFG, 16'h7FFF);
      access(pmw_pkg::PMW_SPACE_IO, 16'h0001, c, h);
      check("max waits", c, 15);
      stall <= 8'h14;
      access(pmw_pkg::PMW_SPACE_IO, 16'h0002, c, h);
      check("ready stall", c, 21);
      stall <= 8'h00;
      wr(`PMW_OFF_WS_CFG, 16'h0000);
      wr(`PMW_OFF_WS_CTRL, 16'h0000);
      check("gen clk off", wsg_clk_en_q, 1'b0);
      access(pmw_pkg::PMW_SPACE_IO, 16'h0003, c, h);
      check("zero waits", c, 1);
   endtask

   task automatic t_trace();
      int c;
      logic h;
      wr(`PMW_OFF_MODE, 16'h0010);
      pc_addr <= 16'hA5A5;
      repeat (3) @(posedge ref_clk);
      check("trace addr", ext_addr_q, 16'hA5A5);
      wr(`PMW_OFF_MODE, 16'h0000);
      access(pmw_pkg::PMW_SPACE_IO, 16'h0123, c, h);
      check("ext space", ext_space_q, pmw_pkg::PMW_SPACE_IO);
      pc_addr <= 16'h5A5A;
      repeat (3) @(posedge ref_clk);
      check("held addr", ext_addr_q, 16'h0123);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset();
      t_mode();
      t_clock();
      t_sat();
      t_map();
      t_waits();
      t_trace();
      final_report();
   end

   initial
   begin
      #2000000;
      fail_count++;
      final_report();
   end
endmodule

`default_nettype wire
